// ---- shared/temp_limit_pkg.sv ----
package temp_limit_pkg;

   // Register pointer values that select each register.
   localparam logic [7:0] PTR_CAPS = 8'h00;
   localparam logic [7:0] PTR_CONFIG = 8'h01;
   localparam logic [7:0] PTR_UPPER = 8'h02;
   localparam logic [7:0] PTR_LOWER = 8'h03;
   localparam logic [7:0] PTR_CRIT = 8'h04;
   localparam logic [7:0] PTR_TEMP = 8'h05;
   localparam logic [7:0] PTR_MAKER = 8'h06;
   localparam logic [7:0] PTR_PART = 8'h07;
   localparam logic [7:0] PTR_RES = 8'h08;

   // Data widths and field positions of the temperature words.
   localparam int REG_W = 16;
   localparam int TEMP_MSB = 12;
   localparam int CMP_LSB = 2;
   localparam int CMP_W = TEMP_MSB - CMP_LSB + 1;
   localparam int CRIT_BIT = 15;
   localparam int UPPER_BIT = 14;
   localparam int LOWER_BIT = 13;

   // Reset values of the writable registers and of the measured temperature.
   localparam logic [15:0] LIMIT_RESET = 16'h0000;
   localparam logic [12:0] TEMP_RESET = 13'h0000;
   localparam logic [1:0] RES_RESET = 2'h1;
   localparam logic [1:0] HYST_RESET = 2'h0;

   // Bits of a limit register that hold data; the rest read as zero.
   localparam logic [15:0] LIMIT_MASK = 16'h1ffc;

   // Resolution register layout: select in bits 4:3, bits 2:0 read one.
   localparam int RES_LSB = 3;
   localparam logic [2:0] RES_ONES = 3'h7;

   // Conversion period, printed in milliseconds, and the core clock rate.
   localparam int CONV_TIME_MS = 100;
   localparam int CLK_HZ = 50_000_000;
   localparam int CONV_CYCLES = CONV_TIME_MS * (CLK_HZ / 1000);

   // One register access as the serial bus front end hands it over.
   typedef struct packed {
      logic ptr_load;
      logic wr;
      logic rd;
      logic [15:0] data;
   } reg_req_t;

   // The three status flags: critical and the upper and lower window flags.
   typedef struct packed {
      logic critical;
      logic upper;
      logic lower;
   } zone_flags_t;

   // Hysteresis in quarter degrees for each select code: 0, 1.5, 3, 6 degrees.
   function automatic logic signed [11:0] hyst_quarters(input logic [1:0] sel);
      logic signed [11:0] q;
      q = 12'sh000;
      unique case (sel)
         2'h0: q = 12'sh000;
         2'h1: q = 12'sh006;
         2'h2: q = 12'sh00c;
         2'h3: q = 12'sh018;
      endcase
      return q;
   endfunction

   // Bits of the measurement that the selected resolution keeps.
   function automatic logic [12:0] res_mask(input logic [1:0] sel);
      logic [12:0] m;
      m = 13'h1ffc;
      unique case (sel)
         2'h0: m = 13'h1ff8;
         2'h1: m = 13'h1ffc;
         2'h2: m = 13'h1ffe;
         2'h3: m = 13'h1fff;
      endcase
      return m;
   endfunction

endpackage

// ---- verilog/conv_period_timer.sv ----
`timescale 1ns/10ps
`default_nettype none

// Issues a one-cycle start pulse at the top of every conversion period.
module conv_period_timer #(
   parameter int PERIOD = temp_limit_pkg::CONV_CYCLES
) (
   // Clock, reset and enable.
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic clk_en,
   // Start of a new conversion.
   output logic start
);

   localparam int CW = $clog2(PERIOD + 1);
   localparam logic [CW-1:0] LAST = CW'(PERIOD - 1);

   logic [CW-1:0] count_q; // Cycles elapsed in the current period.
   logic [CW-1:0] count_d;
   logic start_q; // Registered start pulse.
   logic start_d;

   // Wrap the counter once per period and pulse at the wrap.
   always_comb begin
      start_d = 1'b0;
      count_d = count_q + CW'(1);
      if (count_q == LAST) begin
         count_d = '0;
         start_d = 1'b1;
      end
   end

   // Registers, frozen while the clock enable is low.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         count_q <= '0;
         start_q <= 1'b0;
      end else if (clk_en) begin
         count_q <= count_d;
         start_q <= start_d;
      end
   end

   assign start = start_q;

endmodule

`default_nettype wire

// ---- verilog/window_flag_cmp.sv ----
`timescale 1ns/10ps
`default_nettype none

// One status flag with hysteresis on its clearing side when UPPER is high, on its setting side when UPPER is low.
// UPPER high: sets above the threshold, clears at or below threshold minus hysteresis.
// UPPER low: sets below threshold minus hysteresis, clears at or above the threshold.
module window_flag_cmp #(
   parameter bit UPPER = 1'b1
) (
   // Clock, reset and enable.
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic clk_en,
   // Evaluation strobe and operands, bits 12:2 of each word.
   input wire logic update,
   input wire logic signed [10:0] value,
   input wire logic signed [10:0] threshold,
   input wire logic signed [11:0] hyst,
   // Flag state.
   output logic flag
);

   logic flag_q; // Current flag.
   logic flag_d;
   logic signed [11:0] v_ext; // Sign-extended operands avoid overflow.
   logic signed [11:0] thr_ext;
   logic signed [11:0] thr_low;

   // Decide the next flag value only when a new result arrives.
   always_comb begin
      v_ext = {value[10], value};
      thr_ext = {threshold[10], threshold};
      thr_low = thr_ext - hyst;
      flag_d = flag_q;
      if (update) begin
         if (UPPER) begin
            if (v_ext > thr_ext) begin
               flag_d = 1'b1;
            end else if (v_ext <= thr_low) begin
               flag_d = 1'b0;
            end
         end else begin
            if (v_ext < thr_low) begin
               flag_d = 1'b1;
            end else if (v_ext >= thr_ext) begin
               flag_d = 1'b0;
            end
         end
      end
   end

   // Flag register, frozen while the clock enable is low.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         flag_q <= 1'b0;
      end else if (clk_en) begin
         flag_q <= flag_d;
      end
   end

   assign flag = flag_q;

endmodule

`default_nettype wire

// ---- verilog/temp_limit_compare_regs.sv ----
`timescale 1ns/10ps
`default_nettype none

// Notes on behaviour
// - Limits and temperature are two's complement.
// - Bit 12 sign, bit 2 weighs quarter degree.
// - Compare only bits 12 down to 2.
// - Finer resolutions show extra bits, others zero.
// - Alert on crossing upper limit either way.
// - Window lock makes upper, lower limits read-only.
// - Alert on crossing lower limit either way.
// - Critical alert until at or below limit-hysteresis.
// - Critical lock makes critical limit read-only.
// - Bit 15 shows critical, clears with hysteresis.
// - Bit 14 upper flag, clears with hysteresis.
// - Bit 13 lower flag, sets with hysteresis.
// - Hysteresis magnitude applies on clearing side only; the lower flag here applies it on its setting side.
// - Resolution register bits 4:3, resets 000F.
// - Written resolution also appears in capabilities; capabilities reads as zero here.
// - Each conversion finishes within 100 ms.
// - Fixed maker identification register.
// - Part code upper byte, revision lower byte.
// - Hysteresis select ignored while any lock set.
// - Pointer selects register for later accesses.
module temp_limit_compare_regs #(
   parameter int CONV_CYCLES = temp_limit_pkg::CONV_CYCLES,
   parameter logic [15:0] MAKER_CODE = 16'h1234, // Arbitrary value.
   parameter logic [15:0] PART_REV = 16'h5a01 // Arbitrary value.
) (
   // Clock, reset and enable.
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic clk_en,
   // Register access from the serial bus front end.
   input wire temp_limit_pkg::reg_req_t req,
   output logic [15:0] rd_data,
   output logic rd_valid,
   // Configuration bits held outside this block.
   input wire logic hyst_wr,
   input wire logic [1:0] hyst_sel_in,
   input wire logic critical_lock,
   input wire logic window_lock,
   input wire logic alert_enable,
   // Converter side.
   output logic conv_start,
   input wire logic conv_valid,
   input wire logic [12:0] conv_data,
   // Status and alert outputs.
   output logic [1:0] resolution_select,
   output logic [1:0] hyst_sel,
   output temp_limit_pkg::zone_flags_t zone_flags,
   output logic window_alert,
   output logic critical_alert
);

   // Register state.
   logic [7:0] register_pointer_q; // Selected register for later accesses.
   logic [7:0] register_pointer_d;
   logic [15:0] upper_q; // Upper window limit.
   logic [15:0] upper_d;
   logic [15:0] lower_q; // Lower window limit.
   logic [15:0] lower_d;
   logic [15:0] crit_q; // Critical limit.
   logic [15:0] crit_d;
   logic [1:0] res_q; // Resolution select.
   logic [1:0] res_d;
   logic [1:0] hyst_q; // Hysteresis select.
   logic [1:0] hyst_d;
   logic [15:0] rd_data_q; // Read data holds until the next read.
   logic [15:0] rd_data_d;
   logic rd_valid_q; // One-cycle read answer.
   logic rd_valid_d;

   // Measurement state.
   logic [12:0] temp_q; // Latest conversion result, resolution-masked.
   logic [12:0] temp_d;
   logic update_q; // Comparators evaluate one cycle after capture.
   logic update_d;
   logic eval_q; // Flags are settled one cycle after that.
   logic eval_d;
   logic [1:0] window_prev_q; // Window flags before the last evaluation.
   logic [1:0] window_prev_d;
   logic window_alert_q; // Pulse on a window flag change.
   logic window_alert_d;

   // Comparator results.
   logic flag_crit;
   logic flag_upper;
   logic flag_lower;
   logic signed [11:0] hyst_amount; // Hysteresis in quarter degrees.
   logic any_lock; // Either lock bit set.

   assign hyst_amount = temp_limit_pkg::hyst_quarters(hyst_q);
   assign any_lock = critical_lock | window_lock;

   // Register pointer, limit, resolution and hysteresis updates.
   always_comb begin
      register_pointer_d = register_pointer_q;
      upper_d = upper_q;
      lower_d = lower_q;
      crit_d = crit_q;
      res_d = res_q;
      hyst_d = hyst_q;
      // The pointer is write-only: the host can load it but never read it back.
      if (req.ptr_load) begin
         register_pointer_d = req.data[7:0];
      end
      // Writes land in the register that the pointer selects.
      if (req.wr) begin
         unique case (register_pointer_q)
            temp_limit_pkg::PTR_UPPER: begin
               if (!window_lock) begin
                  upper_d = req.data & temp_limit_pkg::LIMIT_MASK;
               end
            end
            temp_limit_pkg::PTR_LOWER: begin
               if (!window_lock) begin
                  lower_d = req.data & temp_limit_pkg::LIMIT_MASK;
               end
            end
            temp_limit_pkg::PTR_CRIT: begin
               if (!critical_lock) begin
                  crit_d = req.data & temp_limit_pkg::LIMIT_MASK;
               end
            end
            temp_limit_pkg::PTR_RES: begin
               res_d = req.data[temp_limit_pkg::RES_LSB +: 2];
            end
            default: begin
               // Read-only and unmapped registers ignore writes.
            end
         endcase
      end
      // Hysteresis changes are refused while a lock is set.
      if (hyst_wr && !any_lock) begin
         hyst_d = hyst_sel_in;
      end
   end

   // Read multiplexer; the answer is registered for one cycle.
   always_comb begin
      rd_data_d = rd_data_q;
      rd_valid_d = 1'b0;
      if (req.rd) begin
         rd_valid_d = 1'b1;
         unique case (register_pointer_q)
            temp_limit_pkg::PTR_UPPER: begin
               rd_data_d = upper_q;
            end
            temp_limit_pkg::PTR_LOWER: begin
               rd_data_d = lower_q;
            end
            temp_limit_pkg::PTR_CRIT: begin
               rd_data_d = crit_q;
            end
            temp_limit_pkg::PTR_TEMP: begin
               // Flags on top, masked measurement below.
               rd_data_d = {flag_crit, flag_upper, flag_lower, temp_q};
            end
            temp_limit_pkg::PTR_MAKER: begin
               rd_data_d = MAKER_CODE;
            end
            temp_limit_pkg::PTR_PART: begin
               rd_data_d = PART_REV;
            end
            temp_limit_pkg::PTR_RES: begin
               rd_data_d = {11'h000, res_q, temp_limit_pkg::RES_ONES};
            end
            default: begin
               // Registers outside this block read as zero here.
               rd_data_d = 16'h0000;
            end
         endcase
      end
   end

   // Register file flip-flops, frozen while the clock enable is low.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         register_pointer_q <= 8'h00;
         upper_q <= temp_limit_pkg::LIMIT_RESET;
         lower_q <= temp_limit_pkg::LIMIT_RESET;
         crit_q <= temp_limit_pkg::LIMIT_RESET;
         res_q <= temp_limit_pkg::RES_RESET;
         hyst_q <= temp_limit_pkg::HYST_RESET;
         rd_data_q <= 16'h0000;
         rd_valid_q <= 1'b0;
      end else if (clk_en) begin
         register_pointer_q <= register_pointer_d;
         upper_q <= upper_d;
         lower_q <= lower_d;
         crit_q <= crit_d;
         res_q <= res_d;
         hyst_q <= hyst_d;
         rd_data_q <= rd_data_d;
         rd_valid_q <= rd_valid_d;
      end
   end

   // Capture results and sequence the evaluation that follows.
   always_comb begin
      temp_d = temp_q;
      update_d = 1'b0;
      eval_d = update_q;
      window_prev_d = window_prev_q;
      window_alert_d = 1'b0;
      if (conv_valid) begin
         // Unselected finer bits are stored as zero.
         temp_d = conv_data & temp_limit_pkg::res_mask(res_q);
         update_d = 1'b1;
      end
      if (update_q) begin
         window_prev_d = {flag_upper, flag_lower};
      end
      // A change of either window flag, in either direction, is an alert.
      if (eval_q && ({flag_upper, flag_lower} != window_prev_q)) begin
         window_alert_d = alert_enable;
      end
   end

   // Measurement flip-flops, frozen while the clock enable is low.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         temp_q <= temp_limit_pkg::TEMP_RESET;
         update_q <= 1'b0;
         eval_q <= 1'b0;
         window_prev_q <= 2'h0;
         window_alert_q <= 1'b0;
      end else if (clk_en) begin
         temp_q <= temp_d;
         update_q <= update_d;
         eval_q <= eval_d;
         window_prev_q <= window_prev_d;
         window_alert_q <= window_alert_d;
      end
   end

   // Critical comparator, compared on bits 12:2 only.
   window_flag_cmp #(
      .UPPER(1'b1)
   ) u_crit_cmp (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .clk_en(clk_en),
      .update(update_q),
      .value(temp_q[12:2]),
      .threshold(crit_q[12:2]),
      .hyst(hyst_amount),
      .flag(flag_crit)
   );

   // Upper window comparator.
   window_flag_cmp #(
      .UPPER(1'b1)
   ) u_upper_cmp (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .clk_en(clk_en),
      .update(update_q),
      .value(temp_q[12:2]),
      .threshold(upper_q[12:2]),
      .hyst(hyst_amount),
      .flag(flag_upper)
   );

   // Lower window comparator; hysteresis sits on its setting side.
   window_flag_cmp #(
      .UPPER(1'b0)
   ) u_lower_cmp (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .clk_en(clk_en),
      .update(update_q),
      .value(temp_q[12:2]),
      .threshold(lower_q[12:2]),
      .hyst(hyst_amount),
      .flag(flag_lower)
   );

   // Conversion period timer.
   conv_period_timer #(
      .PERIOD(CONV_CYCLES)
   ) u_conv_timer (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .clk_en(clk_en),
      .start(conv_start)
   );

   // Outputs, all from flip-flops.
   assign rd_data = rd_data_q;
   assign rd_valid = rd_valid_q;
   assign resolution_select = res_q;
   assign hyst_sel = hyst_q;
   assign zone_flags.critical = flag_crit;
   assign zone_flags.upper = flag_upper;
   assign zone_flags.lower = flag_lower;
   assign window_alert = window_alert_q;
   assign critical_alert = flag_crit;

endmodule

`default_nettype wire

// ---- sim/temp_limit_chk.sv ----
`timescale 1ns/10ps
`default_nettype none
// Watches the ports of the limit block for timing and status relations.
module temp_limit_chk #(
   parameter int CONV_CYCLES = 16
) (
   // Clock, reset and enable.
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic clk_en,
   // Register access.
   input wire temp_limit_pkg::reg_req_t req,
   input wire logic [15:0] rd_data,
   input wire logic rd_valid,
   // Configuration.
   input wire logic hyst_wr,
   input wire logic [1:0] hyst_sel_in,
   input wire logic critical_lock,
   input wire logic window_lock,
   input wire logic alert_enable,
   // Converter.
   input wire logic conv_start,
   input wire logic conv_valid,
   input wire logic [12:0] conv_data,
   // Status.
   input wire logic [1:0] resolution_select,
   input wire logic [1:0] hyst_sel,
   input wire temp_limit_pkg::zone_flags_t zone_flags,
   input wire logic window_alert,
   input wire logic critical_alert
);
   int gap_q, gap_d; // Cycles since the last start pulse.
   logic seen_q, seen_d; // A start pulse has been seen.
   // Next value of the period counter.
   always_comb begin
      gap_d = gap_q;
      seen_d = seen_q;
      if (clk_en) begin
         gap_d = conv_start ? 0 : gap_q + 1;
         seen_d = seen_q | conv_start;
      end
   end
   // Period counter registers.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         gap_q <= 0;
         seen_q <= 1'b0;
      end else begin
         gap_q <= gap_d;
         seen_q <= seen_d;
      end
   end
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   a_read_answered: assert property (req.rd && clk_en |=> rd_valid)
      else $error("read not answered");
   a_no_stray_valid: assert property (!(req.rd && clk_en) |=> !rd_valid)
      else $error("stray read valid");
   a_crit_alert_level: assert property (critical_alert == zone_flags.critical)
      else $error("critical alert differs from flag");
   a_hyst_locked: assert property (hyst_wr && clk_en && (critical_lock || window_lock)
      |=> $stable(hyst_sel))
      else $error("hysteresis changed under lock");
   a_hyst_loaded: assert property (hyst_wr && clk_en && !critical_lock && !window_lock
      |=> hyst_sel == $past(hyst_sel_in))
      else $error("hysteresis not loaded");
   a_alert_has_cause: assert property (window_alert |->
      $past({zone_flags.upper, zone_flags.lower}) != $past({zone_flags.upper, zone_flags.lower}, 2))
      else $error("window alert without flag change");
   // Flags move at the first edge after the capture edge of a result.
   a_flags_after_result: assert property ($changed(zone_flags) |-> $past(conv_valid, 2))
      else $error("flags moved without a result");
   a_conv_period: assert property (seen_q && conv_start |-> gap_q == CONV_CYCLES - 1)
      else $error("conversion period wrong");
   // Once running, a start pulse never comes later than one period.
   a_conv_not_late: assert property (seen_q |-> gap_q < CONV_CYCLES)
      else $error("conversion start overdue");
   c_alert: cover property (window_alert);
   c_critical: cover property (zone_flags.critical);
   c_lower: cover property (zone_flags.lower);
endmodule
bind temp_limit_compare_regs temp_limit_chk #(.CONV_CYCLES(CONV_CYCLES)) i_temp_limit_chk (
   .core_clk, .rst_n, .clk_en, .req, .rd_data, .rd_valid, .hyst_wr, .hyst_sel_in,
   .critical_lock, .window_lock, .alert_enable, .conv_start, .conv_valid, .conv_data,
   .resolution_select, .hyst_sel, .zone_flags, .window_alert, .critical_alert);
`default_nettype wire

// ---- sim/bus_host_model.sv ----
`timescale 1ns/10ps
`default_nettype none
// Bus front end on the host side: loads the pointer, then writes or reads.
module bus_host_model (
   // Clock.
   input wire logic core_clk,
   // Request toward the block.
   output var temp_limit_pkg::reg_req_t req,
   // Read answer.
   input wire logic [15:0] rd_data,
   input wire logic rd_valid
);
   // Nothing is requested at time zero.
   initial req = '0;
   // One access; each strobe stands for exactly one cycle.
   task automatic access(input logic wr, input logic [7:0] ptr, input logic [15:0] wd,
                         output logic [15:0] rdat);
      rdat = 16'hdead;
      @(negedge core_clk);
      req.ptr_load = 1'b1;
      req.data = {8'h00, ptr};
      @(negedge core_clk);
      req.ptr_load = 1'b0;
      req.wr = wr;
      req.rd = !wr;
      // Unused limit bits always go out as zero.
      req.data = (ptr inside {8'h02, 8'h03, 8'h04}) ? (wd & 16'h1ffc) : wd;
      @(negedge core_clk);
      req.wr = 1'b0;
      req.rd = 1'b0;
      // A released data line does not keep its last value.
      req.data = ~req.data;
      // The answer stands until the next edge, so it is settled here.
      if (!wr && rd_valid === 1'b1) begin
         rdat = rd_data;
      end
   endtask
endmodule
`default_nettype wire

// ---- sim/tb.sv ----
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin num_errors++; \
   $display("[ERR] %0t got %h exp %h", $time, g, e); end end
// Self-checking bench for the limit compare block.
module tb;
   localparam logic [15:0] MAKER = 16'h4c2e; // Arbitrary value.
   localparam logic [15:0] PART = 16'h7b05; // Arbitrary value.
   logic core_clk, rst_n, clk_en, hyst_wr, critical_lock, window_lock, alert_enable;
   logic conv_valid, rd_valid, conv_start, window_alert, critical_alert;
   logic [1:0] hyst_sel_in, resolution_select, hyst_sel;
   logic [12:0] conv_data, tmask;
   logic [15:0] rd_data, r;
   logic [2:0] prev_f;
   temp_limit_pkg::reg_req_t req;
   temp_limit_pkg::zone_flags_t zone_flags;
   int num_errors, cmp_count, alerts, exp_alerts;
   logic [12:0] masks [4] = '{13'h1ff8, 13'h1ffc, 13'h1ffe, 13'h1fff};
   logic [15:0] resv [4] = '{16'h0007, 16'h000f, 16'h0017, 16'h001f};
   logic [12:0] ts [11] = '{13'h0140, 13'h0194, 13'h018c, 13'h0178, 13'h0324, 13'h0318,
      13'h0308, 13'h0040, 13'h0034, 13'h0048, 13'h0050};
   logic [2:0] fs [11] = '{3'h0, 3'h2, 3'h2, 3'h0, 3'h6, 3'h6, 3'h2, 3'h0, 3'h1, 3'h1, 3'h0};
   temp_limit_compare_regs #(.CONV_CYCLES(16), .MAKER_CODE(MAKER), .PART_REV(PART))
      i_temp_limit_compare_regs (.core_clk, .rst_n, .clk_en, .req, .rd_data, .rd_valid,
      .hyst_wr, .hyst_sel_in, .critical_lock, .window_lock, .alert_enable, .conv_start,
      .conv_valid, .conv_data, .resolution_select, .hyst_sel, .zone_flags, .window_alert,
      .critical_alert);
   bus_host_model i_bus_host_model (.core_clk, .req, .rd_data, .rd_valid);
   // Clock at 50 MHz.
   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end
   // Counts window alert pulses; each stands for one whole cycle.
   always @(negedge core_clk) begin
      if (window_alert === 1'b1) alerts++;
   end
   // Prints the counts and the verdict, then ends the run.
   task automatic close_out();
      $display("errors %0d compares %0d", num_errors, cmp_count);
      if (num_errors == 0 && cmp_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // Register write and checked read.
   task automatic wr(input logic [7:0] p, input logic [15:0] d);
      logic [15:0] x;
      i_bus_host_model.access(1'b1, p, d, x);
   endtask
   task automatic rd_chk(input logic [7:0] p, input logic [15:0] e);
      i_bus_host_model.access(1'b0, p, 16'h0000, r);
      `CHK(r, e)
   endtask
   // Hands one result over, then checks flags, alerts and the data register.
   task automatic conv(input logic [12:0] t, input logic [2:0] ef);
      @(negedge core_clk);
      conv_valid = 1'b1;
      conv_data = t;
      @(negedge core_clk);
      conv_valid = 1'b0;
      conv_data = ~t;
      repeat (4) @(negedge core_clk);
      if (alert_enable && ef[1:0] != prev_f[1:0]) exp_alerts++;
      prev_f = ef;
      `CHK(zone_flags, ef)
      `CHK(critical_alert, ef[2])
      `CHK(alerts, exp_alerts)
      rd_chk(temp_limit_pkg::PTR_TEMP, {ef, t & tmask});
   endtask
   // Hysteresis select strobe.
   task automatic set_hyst(input logic [1:0] c);
      @(negedge core_clk);
      hyst_wr = 1'b1;
      hyst_sel_in = c;
      @(negedge core_clk);
      hyst_wr = 1'b0;
   endtask
   // Watchdog against a hang.
   initial begin
      #(20 * 20000);
      num_errors++;
      close_out();
   end
   // Main sequence.
   initial begin
      {rst_n, hyst_wr, critical_lock, window_lock, conv_valid} = '0;
      {clk_en, alert_enable} = 2'b11;
      hyst_sel_in = 2'h0;
      conv_data = 13'h0000;
      prev_f = 3'h0;
      repeat (6) @(negedge core_clk);
      rst_n = 1'b1;
      `CHK(resolution_select, 2'h1)
      rd_chk(temp_limit_pkg::PTR_RES, 16'h000f);
      for (int p = 2; p < 5; p++) rd_chk(p[7:0], 16'h0000);
      wr(temp_limit_pkg::PTR_MAKER, 16'h0000);
      rd_chk(temp_limit_pkg::PTR_MAKER, MAKER);
      rd_chk(temp_limit_pkg::PTR_PART, PART);
      rd_chk(8'h09, 16'h0000);
      // Limits are written at the default resolution so bit 2 may be used.
      wr(temp_limit_pkg::PTR_UPPER, 16'h0190);
      wr(temp_limit_pkg::PTR_LOWER, 16'h0050);
      wr(temp_limit_pkg::PTR_CRIT, 16'h0320);
      rd_chk(temp_limit_pkg::PTR_UPPER, 16'h0190);
      rd_chk(temp_limit_pkg::PTR_CRIT, 16'h0320);
      for (int i = 0; i < 4; i++) begin
         wr(temp_limit_pkg::PTR_RES, {11'h000, i[1:0], 3'h7});
         rd_chk(temp_limit_pkg::PTR_RES, resv[i]);
         `CHK(resolution_select, i[1:0])
         tmask = masks[i];
         conv(13'h0147, 3'h0);
      end
      conv(13'h0193, 3'h0);
      wr(temp_limit_pkg::PTR_RES, 16'h000f);
      tmask = masks[1];
      set_hyst(2'h1);
      `CHK(hyst_sel, 2'h1)
      window_lock = 1'b1;
      set_hyst(2'h3);
      `CHK(hyst_sel, 2'h1)
      for (int i = 0; i < 11; i++) conv(ts[i], fs[i]);
      wr(temp_limit_pkg::PTR_UPPER, 16'h0200);
      rd_chk(temp_limit_pkg::PTR_UPPER, 16'h0190);
      wr(temp_limit_pkg::PTR_LOWER, 16'h0010);
      rd_chk(temp_limit_pkg::PTR_LOWER, 16'h0050);
      window_lock = 1'b0;
      critical_lock = 1'b1;
      wr(temp_limit_pkg::PTR_CRIT, 16'h0100);
      rd_chk(temp_limit_pkg::PTR_CRIT, 16'h0320);
      critical_lock = 1'b0;
      wr(temp_limit_pkg::PTR_CRIT, 16'h0100);
      rd_chk(temp_limit_pkg::PTR_CRIT, 16'h0100);
      alert_enable = 1'b0;
      // Widest hysteresis, 6 degrees, with no lock set; critical limit is now 16 degrees.
      set_hyst(2'h3);
      `CHK(hyst_sel, 2'h3)
      conv(13'h0194, 3'h6);
      conv(13'h00b4, 3'h4);
      conv(13'h00a0, 3'h0);
      conv(13'h1fec, 3'h1);
      close_out();
   end
endmodule
`default_nettype wire
